// file: agc_pkg.sv
package agc_pkg;

    // Register byte addresses on the serial configuration port
    localparam logic [7:0] AGC_ADDR_PORT_CFG = 8'h00;
    localparam logic [7:0] AGC_ADDR_ADVANCE = 8'h71;
    localparam logic [7:0] AGC_ADDR_RATIO = 8'h72;
    localparam logic [7:0] AGC_ADDR_FORMAT = 8'h73;
    localparam logic [7:0] AGC_ADDR_TIMING = 8'h74;
    localparam logic [7:0] AGC_ADDR_LOOP = 8'h75;
    localparam logic [7:0] AGC_ADDR_TEST = 8'hc0;
    localparam logic [7:0] AGC_ADDR_W1_LO = 8'hc2;
    localparam logic [7:0] AGC_ADDR_W1_HI = 8'hc3;
    localparam logic [7:0] AGC_ADDR_W2_LO = 8'hc4;
    localparam logic [7:0] AGC_ADDR_W2_HI = 8'hc5;

    // Field positions
    localparam int AGC_BIT_SOFT_RESET = 5;
    localparam int AGC_BIT_ADVANCE = 0;
    localparam int AGC_BIT_DLL_SLOW = 6;
    localparam int AGC_BIT_DDR = 4;
    localparam int AGC_DRV_LSB = 5;
    localparam int AGC_TMODE_LSB = 6;

    // Reset values
    localparam logic [7:0] AGC_RST_BYTE = 8'h00;
    localparam logic [7:0] AGC_RST_TIMING = 8'h10;
    localparam logic [15:0] AGC_RST_WORD = 16'h0000;

    // One-hot selection codes, plus all-zero for the pin default, shared by the three mode fields
    typedef enum logic [2:0] {
        AGC_SEL_PIN = 3'b000,
        AGC_SEL_A = 3'b001,
        AGC_SEL_B = 3'b010,
        AGC_SEL_C = 3'b100
    } agc_sel_t;

    // Test pattern codes and fixed words
    localparam logic [1:0] AGC_TMODE_STATIC = 2'h0;
    localparam logic [1:0] AGC_TMODE_ALT = 2'h1;
    localparam logic [3:0] AGC_PAT_OFF = 4'h0;
    localparam logic [3:0] AGC_PAT_MID = 4'h1;
    localparam logic [3:0] AGC_PAT_ONES = 4'h2;
    localparam logic [3:0] AGC_PAT_ZEROS = 4'h3;
    localparam logic [3:0] AGC_PAT_CHECK = 4'h4;
    localparam logic [3:0] AGC_PAT_ONEZERO = 4'h7;
    localparam logic [3:0] AGC_PAT_USER = 4'h8;
    localparam logic [15:0] AGC_WORD_MID = 16'h8000;
    localparam logic [15:0] AGC_WORD_ONES = 16'hffff;
    localparam logic [15:0] AGC_WORD_ZEROS = 16'h0000;
    localparam logic [15:0] AGC_WORD_CHK1 = 16'haaaa;
    localparam logic [15:0] AGC_WORD_CHK2 = 16'h5555;

    // Defaults used when the selection pins are absent
    localparam logic [2:0] AGC_NOPIN_DIV = 3'b001;
    localparam logic [2:0] AGC_NOPIN_DRV = 3'b010;
    localparam logic [2:0] AGC_NOPIN_CODE = 3'b001;

    // Divider counter steps
    localparam logic [1:0] AGC_STEP_NORMAL = 2'h1;
    localparam logic [1:0] AGC_STEP_SLIP = 2'h2;
    localparam logic [1:0] AGC_MASK_DIV1 = 2'h0;
    localparam logic [1:0] AGC_MASK_DIV2 = 2'h1;
    localparam logic [1:0] AGC_MASK_DIV4 = 2'h3;

    // Resolved operating configuration, always one-hot per field
    typedef struct packed {
        logic [2:0] divider;
        logic [2:0] driver;
        logic [2:0] coding;
    } agc_cfg_t;

endpackage

// file: agc_config_regs.sv
//////////////////////////////////////////////////////////////////////////////
module agc_config_regs
    import agc_pkg::*;
#(
    parameter int PATTERN_LAT = 3,
    parameter bit PINS_PRESENT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic [2:0] divider_pin_setting,
    input wire logic [2:0] driver_pin_setting,
    input wire logic [2:0] coding_pin_setting,
    output agc_cfg_t eff_cfg,
    output logic sample_strobe,
    output logic dll_slow,
    output logic ddr_en,
    output logic test_active,
    output logic [15:0] test_word
);

    initial begin
        if (PATTERN_LAT < 1 || PATTERN_LAT > 8) begin
            $error("PATTERN_LAT must lie in 1..8");
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] port_cfg_reg, advance_reg, ratio_reg, format_reg;
    logic [7:0] timing_reg, loop_reg, test_ctrl_reg;
    logic [15:0] word1_reg, word2_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;

    // Address decode
    wire wr_port = reg_wr_en && (reg_addr == AGC_ADDR_PORT_CFG);
    wire wr_adv = reg_wr_en && (reg_addr == AGC_ADDR_ADVANCE);
    wire wr_ratio = reg_wr_en && (reg_addr == AGC_ADDR_RATIO);
    wire wr_fmt = reg_wr_en && (reg_addr == AGC_ADDR_FORMAT);
    wire wr_tim = reg_wr_en && (reg_addr == AGC_ADDR_TIMING);
    wire wr_loop = reg_wr_en && (reg_addr == AGC_ADDR_LOOP);
    wire wr_test = reg_wr_en && (reg_addr == AGC_ADDR_TEST);
    wire wr_w1lo = reg_wr_en && (reg_addr == AGC_ADDR_W1_LO);
    wire wr_w1hi = reg_wr_en && (reg_addr == AGC_ADDR_W1_HI);
    wire wr_w2lo = reg_wr_en && (reg_addr == AGC_ADDR_W2_LO);
    wire wr_w2hi = reg_wr_en && (reg_addr == AGC_ADDR_W2_HI);

    // Soft reset is a one-cycle command, the bit itself never stays set
    wire soft_rst = wr_port && reg_wr_data[AGC_BIT_SOFT_RESET];
    wire clr = srst || soft_rst;

    // Slip only on a 0 to 1 step of the stored bit
    wire slip_go = wr_adv && reg_wr_data[AGC_BIT_ADVANCE] && !advance_reg[AGC_BIT_ADVANCE];

    // Stored value folds in both readbacks so the host XOR yields its wish
    wire [7:0] timing_next = reg_wr_data ^ timing_reg ^ loop_reg;

    // Port config keeps every bit except the self-clearing reset bit
    wire [7:0] port_cfg_next = reg_wr_data & ~(8'h01 << AGC_BIT_SOFT_RESET);

    // Configuration writes; ratio and format ignore soft reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ratio_reg <= AGC_RST_BYTE;
            format_reg <= AGC_RST_BYTE;
            port_cfg_reg <= AGC_RST_BYTE;
        end else begin
            if (wr_ratio) ratio_reg <= reg_wr_data;
            if (wr_fmt) format_reg <= reg_wr_data;
            if (wr_port) port_cfg_reg <= port_cfg_next;
        end
    end

    // Registers returned to defaults by either reset
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            advance_reg <= AGC_RST_BYTE;
            timing_reg <= AGC_RST_TIMING;
            loop_reg <= AGC_RST_BYTE;
            test_ctrl_reg <= AGC_RST_BYTE;
            word1_reg <= AGC_RST_WORD;
            word2_reg <= AGC_RST_WORD;
        end else begin
            if (wr_adv) advance_reg <= reg_wr_data;
            if (wr_tim) timing_reg <= timing_next;
            if (wr_loop) loop_reg <= reg_wr_data;
            if (wr_test) test_ctrl_reg <= reg_wr_data;
            if (wr_w1lo) word1_reg[7:0] <= reg_wr_data;
            if (wr_w1hi) word1_reg[15:8] <= reg_wr_data;
            if (wr_w2lo) word2_reg[7:0] <= reg_wr_data;
            if (wr_w2hi) word2_reg[15:8] <= reg_wr_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Readback mux; unmapped addresses answer zero
    logic [7:0] rd_mux;
    assign rd_mux = (reg_addr == AGC_ADDR_PORT_CFG) ? port_cfg_reg :
                    (reg_addr == AGC_ADDR_ADVANCE) ? advance_reg :
                    (reg_addr == AGC_ADDR_RATIO) ? ratio_reg :
                    (reg_addr == AGC_ADDR_FORMAT) ? format_reg :
                    (reg_addr == AGC_ADDR_TIMING) ? timing_reg :
                    (reg_addr == AGC_ADDR_LOOP) ? loop_reg :
                    (reg_addr == AGC_ADDR_TEST) ? test_ctrl_reg :
                    (reg_addr == AGC_ADDR_W1_LO) ? word1_reg[7:0] :
                    (reg_addr == AGC_ADDR_W1_HI) ? word1_reg[15:8] :
                    (reg_addr == AGC_ADDR_W2_LO) ? word2_reg[7:0] :
                    (reg_addr == AGC_ADDR_W2_HI) ? word2_reg[15:8] : AGC_RST_BYTE;

    // Read data registered one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data_reg <= AGC_RST_BYTE;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
            if (reg_rd_en) rd_data_reg <= rd_mux;
        end
    end
    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    //////////////////////////////////////////////////////////////////////////
    // Mode resolution: pin-default and illegal codes fall to a present one-hot pin, else to the no-pin default
    function automatic logic [2:0] agc_resolve(input logic [2:0] code, input logic [2:0] pin,
                                               input logic [2:0] nopin);
        logic [2:0] fallback;
        fallback = (PINS_PRESENT && $onehot(pin)) ? pin : nopin;
        agc_resolve = $onehot(code) ? code : fallback;
    endfunction

    agc_cfg_t cfg_next;
    agc_cfg_t cfg_reg;
    assign cfg_next.divider = agc_resolve(ratio_reg[2:0], divider_pin_setting,
                                          AGC_NOPIN_DIV);
    assign cfg_next.driver = agc_resolve(format_reg[AGC_DRV_LSB +: 3], driver_pin_setting,
                                         AGC_NOPIN_DRV);
    assign cfg_next.coding = agc_resolve(format_reg[2:0], coding_pin_setting,
                                         AGC_NOPIN_CODE);

    //////////////////////////////////////////////////////////////////////////
    // Divided clock phase counter; in divide by four only, a slip skips one count so the edge comes early
    logic [1:0] cnt_reg;
    logic strobe_reg;
    wire div4 = (cfg_reg.divider == AGC_SEL_C);
    wire div2 = (cfg_reg.divider == AGC_SEL_B);
    wire [1:0] cnt_mask = div4 ? AGC_MASK_DIV4 : (div2 ? AGC_MASK_DIV2 : AGC_MASK_DIV1);
    // A slip landing on the wrap count is held one cycle; skipping there would drop an edge
    logic slip_hold_reg;
    wire slip_now = (slip_go || slip_hold_reg) && div4;
    wire slip_wrap = slip_now && (cnt_reg == AGC_MASK_DIV4);
    wire [1:0] cnt_step = (slip_now && !slip_wrap) ? AGC_STEP_SLIP : AGC_STEP_NORMAL;
    wire [1:0] cnt_next = 2'((cnt_reg + cnt_step) & cnt_mask);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfg_reg <= {AGC_NOPIN_DIV, AGC_NOPIN_DRV, AGC_NOPIN_CODE};
            cnt_reg <= 2'h0;
            strobe_reg <= 1'b0;
            slip_hold_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            cnt_reg <= cnt_next;
            strobe_reg <= (cnt_next == 2'h0);
            slip_hold_reg <= slip_wrap;
        end
    end

    // Edge spacing seen by the checks; saturates so a long gap cannot wrap
    logic [2:0] since_reg;
    logic adv_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            since_reg <= 3'h0;
            adv_reg <= 1'b0;
        end else begin
            since_reg <= strobe_reg ? 3'h1 : ((&since_reg) ? since_reg : 3'(since_reg + 3'h1));
            adv_reg <= (cnt_step == AGC_STEP_SLIP) || (adv_reg && !strobe_reg);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Test control delay line; enabling is not tied to any sample edge
    logic [7:0] tp_pipe_reg [PATTERN_LAT];
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < PATTERN_LAT; i++) tp_pipe_reg[i] <= AGC_RST_BYTE;
        end else begin
            tp_pipe_reg[0] <= test_ctrl_reg;
            for (int i = 1; i < PATTERN_LAT; i++) tp_pipe_reg[i] <= tp_pipe_reg[i-1];
        end
    end

    // Pattern decode from the delayed control byte
    wire [7:0] tp_ctrl = tp_pipe_reg[PATTERN_LAT-1];
    wire [3:0] pat = tp_ctrl[3:0];
    wire alt_mode = (tp_ctrl[AGC_TMODE_LSB +: 2] == AGC_TMODE_ALT);
    logic [15:0] pat_w1, pat_w2;
    logic pat_on, pat_two;
    always_comb begin
        pat_w1 = AGC_WORD_ZEROS;
        pat_w2 = AGC_WORD_ZEROS;
        pat_on = 1'b1;
        pat_two = 1'b0;
        unique case (pat)
            AGC_PAT_MID: pat_w1 = AGC_WORD_MID;
            AGC_PAT_ONES: pat_w1 = AGC_WORD_ONES;
            AGC_PAT_ZEROS: pat_w1 = AGC_WORD_ZEROS;
            AGC_PAT_CHECK: begin
                pat_w1 = AGC_WORD_CHK1;
                pat_w2 = AGC_WORD_CHK2;
                pat_two = 1'b1;
            end
            AGC_PAT_ONEZERO: begin
                pat_w1 = AGC_WORD_ONES;
                pat_w2 = AGC_WORD_ZEROS;
                pat_two = 1'b1;
            end
            AGC_PAT_USER: begin
                pat_w1 = word1_reg;
                pat_w2 = word2_reg;
                pat_two = 1'b1;
            end
            // Off and reserved codes drive no pattern
            default: pat_on = 1'b0;
        endcase
    end

    // Word alternates only when the mode asks and the code has two words
    wire swap = pat_on && alt_mode && pat_two;
    logic phase_reg, active_reg;
    logic [15:0] word_reg;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_reg <= 1'b0;
            active_reg <= 1'b0;
            word_reg <= AGC_RST_WORD;
        end else begin
            active_reg <= pat_on;
            if (!swap) phase_reg <= 1'b0;
            else if (strobe_reg) phase_reg <= ~phase_reg;
            if (!pat_on) word_reg <= AGC_RST_WORD;
            else if (strobe_reg) word_reg <= (swap && phase_reg) ? pat_w2 : pat_w1;
        end
    end

    assign eff_cfg = cfg_reg;
    assign sample_strobe = strobe_reg;
    assign dll_slow = loop_reg[AGC_BIT_DLL_SLOW];
    assign ddr_en = timing_reg[AGC_BIT_DDR];
    assign test_active = active_reg;
    assign test_word = word_reg;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    AST_SLIP_EARLY: assert property (@(posedge clk_sys) disable iff (srst)
        (strobe_reg && adv_reg && div4 && $past(div4, 4)) |-> (since_reg == 3'h3))
        else $error("slip did not advance divided edge by one cycle");
    AST_SLIP_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
        (wr_adv && reg_wr_data[AGC_BIT_ADVANCE] && advance_reg[AGC_BIT_ADVANCE] && div4 &&
         !slip_hold_reg) |=> (cnt_reg == 2'($past(cnt_reg) + 2'h1)))
        else $error("repeated one write moved the divided clock");
    AST_DIV_LEGAL: assert property (@(posedge clk_sys) disable iff (srst)
        (ratio_reg[2:0] == 3'b100) |=> (eff_cfg.divider == 3'b100))
        else $error("divide by four code not applied");
    AST_KEEP_RATIO: assert property (@(posedge clk_sys) disable iff (srst)
        soft_rst |=> $stable(ratio_reg) && $stable(format_reg))
        else $error("soft reset altered ratio or format");
    AST_DRV_ONEHOT: assert property (@(posedge clk_sys) disable iff (srst)
        $onehot(eff_cfg.driver) && $onehot(eff_cfg.divider))
        else $error("driver or divider selection not one-hot");
    AST_CODE_FALLBACK: assert property (@(posedge clk_sys) disable iff (srst)
        (!$onehot(format_reg[2:0]) && !PINS_PRESENT) |=> (eff_cfg.coding == AGC_NOPIN_CODE))
        else $error("illegal coding code did not fall to default");
    AST_DDR_RESET: assert property (@(posedge clk_sys)
        srst |=> ddr_en)
        else $error("double rate not enabled after reset");
    AST_XOR_WRITE: assert property (@(posedge clk_sys) disable iff (srst)
        wr_tim |=> (timing_reg == ($past(reg_wr_data) ^ $past(timing_reg) ^ $past(loop_reg))))
        else $error("timing register XOR write wrong");
    AST_ALT_SWAP: assert property (@(posedge clk_sys) disable iff (srst)
        (swap && $past(swap) && strobe_reg && $past(strobe_reg) && (pat_w1 != pat_w2))
        |=> (word_reg != $past(word_reg)))
        else $error("alternating words did not swap");
    AST_SOFT_CLEAR: assert property (@(posedge clk_sys) disable iff (srst)
        soft_rst |=> (test_ctrl_reg == AGC_RST_BYTE) ##[1:12] !test_active)
        else $error("soft reset did not stop test pattern");

endmodule

// file: agc_host_model.sv
//////////////////////////////////////////////////////////////////////////////
// Host on the configuration port: byte reads and writes, nothing else
module agc_host_model
    import agc_pkg::*;
(
    input wire logic clk_sys,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus shows a changing, meaningless value
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'hff;
        reg_wr_data = 8'hff;
    end

    // One byte write, taken on a single edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(posedge clk_sys);
        #1;
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask

    // Read; data is only trusted with its valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = (reg_rd_valid === 1'b1) ? reg_rd_data : 8'hxx;
    endtask

    // Zero then one, each a separate write
    task automatic slip();
        wr(AGC_ADDR_ADVANCE, 8'h00);
        wr(AGC_ADDR_ADVANCE, 8'h01);
    endtask

    // Range choice belongs to the host; hardware cannot check the rate
    task automatic set_loop(input logic slow);
        wr(AGC_ADDR_LOOP, {1'b0, slow, 6'h00});
    endtask

    // Read both, fold in the wanted value; double rate always kept on
    task automatic set_timing(input logic [7:0] want);
        logic [7:0] t;
        logic [7:0] l;
        rd(AGC_ADDR_TIMING, t);
        rd(AGC_ADDR_LOOP, l);
        wr(AGC_ADDR_TIMING, t ^ l ^ (want | (8'h01 << AGC_BIT_DDR)));
    endtask
endmodule

// file: test_adc_global_config_test_pattern.sv
module test_adc_global_config_test_pattern;
    import agc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] w1;
        logic [15:0] w2;
        logic act;
    } agc_tp_t;

    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, sample_strobe, dll_slow, ddr_en, test_active;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, d;
    logic [15:0] test_word, a, b, ea, eb;
    agc_cfg_t eff_cfg;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int since = 0;
    int gaps[$];
    localparam logic [7:0] ADDRS [12] = '{8'h00, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
                                          8'hc0, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'h01};
    localparam logic [2:0] CODES [6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b011, 3'b111};
    localparam logic [2:0] EDIV [6] = '{3'b001, 3'b001, 3'b010, 3'b100, 3'b001, 3'b001};
    localparam logic [2:0] EDRV [6] = '{3'b010, 3'b001, 3'b010, 3'b100, 3'b010, 3'b010};
    localparam agc_tp_t TPS [11] = '{
        '{8'h01, 16'h8000, 16'h8000, 1'b1}, '{8'h02, 16'hffff, 16'hffff, 1'b1},
        '{8'h03, 16'h0000, 16'h0000, 1'b1}, '{8'h44, 16'haaaa, 16'h5555, 1'b1},
        '{8'h47, 16'hffff, 16'h0000, 1'b1}, '{8'h48, 16'h1234, 16'habcd, 1'b1},
        '{8'h04, 16'haaaa, 16'haaaa, 1'b1}, '{8'hc4, 16'haaaa, 16'haaaa, 1'b1},
        '{8'h41, 16'h8000, 16'h8000, 1'b1}, '{8'h45, 16'h0000, 16'h0000, 1'b0},
        '{8'h00, 16'h0000, 16'h0000, 1'b0}};

    always #20 clk_sys = ~clk_sys;

    agc_config_regs uut (.clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .divider_pin_setting(3'b100), .driver_pin_setting(3'b100),
        .coding_pin_setting(3'b100), .eff_cfg(eff_cfg), .sample_strobe(sample_strobe),
        .dll_slow(dll_slow), .ddr_en(ddr_en), .test_active(test_active),
        .test_word(test_word));

    agc_host_model host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));

    // Strobe spacing log; a slip in divide by four shows up as one short gap
    always @(posedge clk_sys) begin
        if (sample_strobe === 1'b1) begin
            gaps.push_back(since);
            since = 1;
        end else begin
            since++;
        end
    end

    // Hang guard, generous against a run of about 450 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Every gap must be the divide ratio, apart from n_short gaps one shorter
    task automatic gaps_chk(input int exp, input int n_short);
        int s;
        s = 0;
        foreach (gaps[i])
            if (gaps[i] != exp)
                s += (gaps[i] == exp - 1) ? 1 : 100;
        chk8((gaps.size() > 2) ? 8'(s) : 8'hee, 8'(n_short));
    endtask

    initial begin
        tick(2);
        srst = 1'b0;
        foreach (ADDRS[i]) begin
            host.rd(ADDRS[i], d);
            chk8(d, (ADDRS[i] == 8'h74) ? 8'h10 : 8'h00);
        end
        chk16({7'h0, eff_cfg}, {7'h0, 9'b001_010_001});
        chk8({6'h0, ddr_en, dll_slow}, 8'h02);
        $display("Test reset values done");
        foreach (CODES[i]) begin
            host.wr(8'h72, {5'h0, CODES[i]});
            host.wr(8'h73, {CODES[i], 2'b00, CODES[i]});
            tick(10);
            gaps.delete();
            tick(14);
            chk8({5'h0, eff_cfg.divider}, {5'h0, EDIV[i]});
            chk8({5'h0, eff_cfg.driver}, {5'h0, EDRV[i]});
            chk8({5'h0, eff_cfg.coding}, {5'h0, EDIV[i]});
            gaps_chk(EDIV[i] == 3'b100 ? 4 : EDIV[i] == 3'b010 ? 2 : 1, 0);
        end
        $display("Test mode fields done");
        for (int r = 2; r <= 4; r += 2) begin
            host.wr(8'h72, 8'(r));
            tick(10);
            gaps.delete();
            host.slip();
            host.wr(8'h71, 8'h01);
            tick(16);
            gaps_chk(r, (r == 4) ? 1 : 0);
        end
        host.wr(8'h72, 8'h01);
        $display("Test phase slip done");
        host.set_loop(1'b1);
        chk8({7'h0, dll_slow}, 8'h01);
        host.set_timing(8'h13);
        host.rd(8'h74, d);
        chk8(d, 8'h13);
        chk8({7'h0, ddr_en}, 8'h01);
        $display("Test loop and timing done");
        host.wr(8'hc2, 8'h34);
        host.wr(8'hc3, 8'h12);
        host.wr(8'hc4, 8'hcd);
        host.wr(8'hc5, 8'hab);
        foreach (TPS[i]) begin
            host.wr(8'hc0, TPS[i].ctrl);
            if (i == 0)
                chk8({7'h0, test_active}, 8'h00);
            tick(9);
            a = test_word;
            tick(1);
            b = test_word;
            ea = (a === TPS[i].w2) ? TPS[i].w2 : TPS[i].w1;
            eb = (ea === TPS[i].w1) ? TPS[i].w2 : TPS[i].w1;
            chk16(a, ea);
            chk16(b, eb);
            chk8({7'h0, test_active}, {7'h0, TPS[i].act});
        end
        $display("Test patterns done");
        host.wr(8'hc0, 8'h02);
        host.wr(8'h01, 8'h5a);
        host.wr(8'h72, 8'h02);
        host.wr(8'h73, 8'h84);
        host.wr(8'hc2, 8'h77);
        chk8({7'h0, test_active}, 8'h01);
        host.wr(8'h00, 8'h20);
        foreach (ADDRS[i]) begin
            host.rd(ADDRS[i], d);
            chk8(d, ADDRS[i] == 8'h74 ? 8'h10 : ADDRS[i] == 8'h72 ? 8'h02
                : ADDRS[i] == 8'h73 ? 8'h84 : 8'h00);
        end
        chk8({7'h0, dll_slow}, 8'h00);
        chk8({7'h0, test_active}, 8'h00);
        chk16(test_word, 16'h0000);
        $display("Test soft reset done");
        wrap_up();
    end
endmodule
